// ---- rtcb_calendar.sv ----
// Purpose: BCD calendar clock with alarms, wakeup timer and backup store
// Assumes: Kernel clock inputs are slow levels, synchronous to clk
// Notes:   Behaviour
// Behaviour
// - Time and date held as BCD fields, hours in 12 or 24 hour form.
// - Date advances by month length, including leap February.
// - A detected 50 or 60 Hz reference may supply the seconds tick.
// - Alarm and periodic events can wake from Stop and Standby.
// - Sub-second count is readable in plain binary.
// - Kernel clock chosen from crystal, low-speed RC or fast clock over 128.
// - A 512 Hz calibration output can be driven.
// - Two alarm comparators with each field individually maskable.
// - 16-bit auto-reload down-counter gives periodic wakeup events.
// - 20-bit prescaler, reset value gives one second from 32.768 kHz.
// - Twenty 32-bit backup words are kept.
// - Backup words survive every reset and Standby wakeup.
// - Alarm words hold sub-second, second, minute, hour and day values.
// - The calendar keeps running in Stop and can wake from it.
// - Alarm, wakeup, tamper and stamp events route onto event lines.
// - Standby exit on events, reset pin, watchdog or wakeup pin rise.
// - Backup words retained through Standby.
`timescale 1ns/1ps
module rtcb_calendar
  import rtcb_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire rtcb_pkg::rtcb_cksrc_t ckSel,
  input  wire logic                  ckXtal,
  input  wire logic                  ckLowRc,
  input  wire logic                  ckFastExt,
  input  wire logic                  prescWr,
  input  wire logic [19:0]           prescVal,
  input  wire logic                  refEn,
  input  wire logic                  ref60Hz,
  input  wire logic                  refIn,
  input  wire logic                  calEn,
  input  wire logic                  fmt12,
  input  wire logic                  setStb,
  input  wire logic [7:0]            setSec,
  input  wire logic [7:0]            setMin,
  input  wire logic [7:0]            setHour,
  input  wire logic                  setPm,
  input  wire logic [2:0]            setWday,
  input  wire logic [7:0]            setDate,
  input  wire logic [7:0]            setMonth,
  input  wire logic [7:0]            setYear,
  input  wire logic [1:0]            alarmEn,
  input  wire logic [1:0][19:0]      alarmSub,
  input  wire logic [1:0][7:0]       alarmSec,
  input  wire logic [1:0][7:0]       alarmMin,
  input  wire logic [1:0][7:0]       alarmHour,
  input  wire logic [1:0]            alarmPm,
  input  wire logic [1:0][7:0]       alarmDay,
  input  wire logic [1:0]            alarmWdSel,
  input  wire logic [1:0][4:0]       alarmMask,
  input  wire logic [1:0]            alarmClr,
  input  wire logic                  wkEn,
  input  wire rtcb_pkg::rtcb_wkres_t wkSel,
  input  wire logic [15:0]           wkReload,
  input  wire logic                  wkClr,
  input  wire logic                  tamperIn,
  input  wire logic                  tamperClr,
  input  wire logic                  stampIn,
  input  wire logic                  stampClr,
  input  wire logic [3:0]            evtRoute,
  input  wire logic                  extResetPinN,
  input  wire logic                  watchdogRst,
  input  wire logic                  wakeupPin,
  input  wire logic                  bkpWe,
  input  wire logic [BKP_AW-1:0]     bkpAddr,
  input  wire logic [31:0]           bkpWdata,
  output logic      [31:0]           bkpRdata_ff,
  output logic      [7:0]            sec_ff,
  output logic      [7:0]            min_ff,
  output logic      [7:0]            hour_ff,
  output logic                       pm_ff,
  output logic      [2:0]            wday_ff,
  output logic      [7:0]            date_ff,
  output logic      [7:0]            month_ff,
  output logic      [7:0]            year_ff,
  output logic      [19:0]           subSec_ff,
  output logic                       refDetected_ff,
  output logic                       calOut_ff,
  output logic      [1:0]            alarmFlag_ff,
  output logic                       wkFlag_ff,
  output logic                       tamperFlag_ff,
  output logic                       stampFlag_ff,
  output logic      [3:0]            evtLine_ff,
  output logic                       wakeStop_ff,
  output logic                       wakeStandby_ff
);
  logic        rstMeta_ff, rstSyncN;
  logic        ckPrev_ff, fastPrev_ff, refPrev_ff, kTick, refEdge, secTick;
  logic [6:0]  fastDiv_ff;
  logic        ckLevel, ckEdge;
  logic [19:0] prescReload_ff;
  logic [5:0]  refCnt_ff;
  logic [1:0]  refMiss_ff;
  logic        prescSec;
  logic [4:0]  calCnt_ff;
  logic [3:0]  kDiv_ff;
  logic        wkTick, wkEnPrev_ff;
  logic [15:0] wkCnt_ff;
  logic        tamperPrev_ff, stampPrev_ff, wakePinPrev_ff;
  logic [1:0]  alarmHit, alarmHitPrev_ff;
  logic [3:0]  evtSet;
  logic [7:0]  nxtSec, nxtMin, nxtHour;
  logic        nxtPm, dayCarry;
  logic [7:0]  monthDays;

  // Reset release through two flops; the async path only clears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_ff <= 1'b0;
      rstSyncN   <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSyncN   <= rstMeta_ff;
    end
  end

  // Kernel clock selection and edge detection
  always_comb begin
    unique case (ckSel)
      RTCB_CK_XTAL: ckLevel = ckXtal;
      RTCB_CK_LSRC: ckLevel = ckLowRc;
      RTCB_CK_FAST: ckLevel = (fastDiv_ff == FAST_DIV_END);
      default:      ckLevel = ckXtal;
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ckPrev_ff   <= 1'b0;
      fastPrev_ff <= 1'b0;
      fastDiv_ff  <= 7'h00;
      refPrev_ff  <= 1'b0;
    end else begin
      ckPrev_ff   <= ckLevel;
      fastPrev_ff <= ckFastExt;
      refPrev_ff  <= refIn;
      if (ckFastExt && !fastPrev_ff) begin
        fastDiv_ff <= fastDiv_ff + 7'h01;
      end
    end
  end

  assign ckEdge  = ckLevel && !ckPrev_ff;
  assign kTick   = ckEdge;
  assign refEdge = refIn && !refPrev_ff;

  // Prescaler; its count doubles as the binary sub-second value
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      prescReload_ff <= PRESC_RST;
      subSec_ff      <= PRESC_RST;
    end else begin
      if (prescWr) begin
        prescReload_ff <= prescVal;
      end
      if (kTick) begin
        subSec_ff <= (subSec_ff == 20'h00000) ? prescReload_ff : subSec_ff - 20'h00001;
      end
    end
  end

  assign prescSec = kTick && (subSec_ff == 20'h00000);

  // Reference detection: lost after two prescaler seconds without an edge
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      refCnt_ff      <= 6'h00;
      refMiss_ff     <= 2'h3;
      refDetected_ff <= 1'b0;
    end else begin
      if (refEdge) begin
        refMiss_ff <= 2'h0;
        refCnt_ff  <= (refCnt_ff == (ref60Hz ? REF60_END : REF50_END)) ? 6'h00 : refCnt_ff + 6'h01;
      end else if (prescSec && refMiss_ff != 2'h3) begin
        refMiss_ff <= refMiss_ff + 2'h1;
      end
      refDetected_ff <= (refMiss_ff < REF_MISS_MAX);
    end
  end

  // Reference takes over the seconds tick only while it is present
  assign secTick = (refEn && refDetected_ff)
                 ? (refEdge && refCnt_ff == (ref60Hz ? REF60_END : REF50_END))
                 : prescSec;

  // Time-of-day roll-over
  always_comb begin
    nxtSec   = sec_ff;
    nxtMin   = min_ff;
    nxtHour  = hour_ff;
    nxtPm    = pm_ff;
    dayCarry = 1'b0;
    if (secTick) begin
      if (sec_ff == SEC_END) begin
        nxtSec = TIME_RST;
        if (min_ff == MIN_END) begin
          nxtMin = TIME_RST;
          if (!fmt12) begin
            nxtHour  = (hour_ff == HOUR24_END) ? TIME_RST : bcd_inc(hour_ff);
            dayCarry = (hour_ff == HOUR24_END);
          end else if (hour_ff == HOUR12_LAST) begin
            nxtHour  = HOUR12_TOP;
            nxtPm    = !pm_ff;
            dayCarry = pm_ff;
          end else begin
            nxtHour = (hour_ff == HOUR12_TOP) ? HOUR12_RST : bcd_inc(hour_ff);
          end
        end else begin
          nxtMin = bcd_inc(min_ff);
        end
      end else begin
        nxtSec = bcd_inc(sec_ff);
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sec_ff  <= TIME_RST;
      min_ff  <= TIME_RST;
      hour_ff <= TIME_RST;
      pm_ff   <= 1'b0;
    end else if (setStb) begin
      sec_ff  <= setSec;
      min_ff  <= setMin;
      hour_ff <= setHour;
      pm_ff   <= setPm;
    end else begin
      sec_ff  <= nxtSec;
      min_ff  <= nxtMin;
      hour_ff <= nxtHour;
      pm_ff   <= nxtPm;
    end
  end

  assign monthDays = days_in_month(month_ff, year_ff);

  // Date roll-over by month length
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wday_ff  <= WDAY_RST;
      date_ff  <= DATE_RST;
      month_ff <= DATE_RST;
      year_ff  <= TIME_RST;
    end else if (setStb) begin
      wday_ff  <= setWday;
      date_ff  <= setDate;
      month_ff <= setMonth;
      year_ff  <= setYear;
    end else if (dayCarry) begin
      wday_ff <= (wday_ff == WDAY_END) ? WDAY_RST : wday_ff + 3'h1;
      if (date_ff == monthDays) begin
        date_ff <= DATE_RST;
        if (month_ff == MONTH_END) begin
          month_ff <= DATE_RST;
          year_ff  <= (year_ff == YEAR_END) ? TIME_RST : bcd_inc(year_ff);
        end else begin
          month_ff <= bcd_inc(month_ff);
        end
      end else begin
        date_ff <= bcd_inc(date_ff);
      end
    end
  end

  // 512 Hz is the kernel tick over 64: toggle every 32 ticks
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      calCnt_ff <= 5'h00;
      calOut_ff <= 1'b0;
    end else if (!calEn) begin
      calCnt_ff <= 5'h00;
      calOut_ff <= 1'b0;
    end else if (kTick) begin
      calCnt_ff <= calCnt_ff + 5'h01;
      if (calCnt_ff == CAL_HALF_END) begin
        calOut_ff <= !calOut_ff;
      end
    end
  end

  // Alarm compare; a masked field always matches
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      alarmHit[i] = alarmEn[i]
        && (alarmMask[i][0] || alarmSec[i] == sec_ff)
        && (alarmMask[i][1] || alarmMin[i] == min_ff)
        && (alarmMask[i][2] || (alarmHour[i] == hour_ff && (!fmt12 || alarmPm[i] == pm_ff)))
        && (alarmMask[i][3] || (alarmWdSel[i] ? alarmDay[i] == {5'h00, wday_ff}
                                              : alarmDay[i] == date_ff))
        && (alarmMask[i][4] || alarmSub[i] == subSec_ff);
    end
  end

  // Wakeup timer resolution
  always_comb begin
    unique case (wkSel)
      RTCB_WK_DIV16: wkTick = kTick && (kDiv_ff == 4'hf);
      RTCB_WK_DIV8:  wkTick = kTick && (kDiv_ff[2:0] == 3'h7);
      RTCB_WK_DIV4:  wkTick = kTick && (kDiv_ff[1:0] == 2'h3);
      RTCB_WK_DIV2:  wkTick = kTick && kDiv_ff[0];
      RTCB_WK_SEC:   wkTick = secTick;
      default:       wkTick = secTick;
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      kDiv_ff     <= 4'h0;
      wkEnPrev_ff <= 1'b0;
      wkCnt_ff    <= 16'h0000;
    end else begin
      wkEnPrev_ff <= wkEn;
      if (kTick) begin
        kDiv_ff <= kDiv_ff + 4'h1;
      end
      if (wkEn && !wkEnPrev_ff) begin
        wkCnt_ff <= wkReload;
      end else if (wkEn && wkTick) begin
        wkCnt_ff <= (wkCnt_ff == 16'h0000) ? wkReload : wkCnt_ff - 16'h0001;
      end
    end
  end

  assign evtSet[0] = |(alarmHit & ~alarmHitPrev_ff);
  assign evtSet[1] = wkEn && wkEnPrev_ff && wkTick && (wkCnt_ff == 16'h0000);
  assign evtSet[2] = tamperIn && !tamperPrev_ff;
  assign evtSet[3] = stampIn && !stampPrev_ff;

  // Sticky event flags: a new event wins over a same-cycle clear
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      alarmHitPrev_ff <= 2'b00;
      alarmFlag_ff    <= 2'b00;
      wkFlag_ff       <= 1'b0;
      tamperFlag_ff   <= 1'b0;
      stampFlag_ff    <= 1'b0;
      tamperPrev_ff   <= 1'b0;
      stampPrev_ff    <= 1'b0;
    end else begin
      alarmHitPrev_ff <= alarmHit;
      tamperPrev_ff   <= tamperIn;
      stampPrev_ff    <= stampIn;
      alarmFlag_ff    <= (alarmHit & ~alarmHitPrev_ff) | (alarmFlag_ff & ~alarmClr);
      wkFlag_ff       <= evtSet[1] || (wkFlag_ff && !wkClr);
      tamperFlag_ff   <= evtSet[2] || (tamperFlag_ff && !tamperClr);
      stampFlag_ff    <= evtSet[3] || (stampFlag_ff && !stampClr);
    end
  end

  // Event line pulses and wake requests
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      evtLine_ff     <= 4'h0;
      wakeStop_ff    <= 1'b0;
      wakeStandby_ff <= 1'b0;
      wakePinPrev_ff <= 1'b0;
    end else begin
      wakePinPrev_ff <= wakeupPin;
      evtLine_ff     <= evtRoute & evtSet;
      wakeStop_ff    <= |(evtRoute & evtSet);
      wakeStandby_ff <= (|evtSet) || !extResetPinN || watchdogRst
                     || (wakeupPin && !wakePinPrev_ff);
    end
  end

  // Store has no reset path so nothing but a write changes it
  rtcb_backup_mem u_bkp (
    .clk      (clk),
    .we       (bkpWe),
    .addr     (bkpAddr),
    .wdata    (bkpWdata),
    .rdata_ff (bkpRdata_ff)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  sequence bkpWr_s;
    bkpWe && (bkpAddr < BKP_AW'(BKP_N)) ##1 !bkpWe && $stable(bkpAddr);
  endsequence
  sequence secWrap_s;
    secTick && !setStb && sec_ff == SEC_END;
  endsequence

  sec_roll_a: assert property (secWrap_s |=> sec_ff == TIME_RST)
    else $error("seconds did not wrap to zero");
  min_carry_a: assert property (secWrap_s ##0 min_ff != MIN_END |=> min_ff == bcd_inc($past(min_ff)))
    else $error("minute carry missing");
  date_wrap_a: assert property (dayCarry && !setStb && date_ff == monthDays |=> date_ff == DATE_RST)
    else $error("date did not wrap at month end");
  presc_reload_a: assert property (prescSec |=> subSec_ff == $past(prescReload_ff))
    else $error("prescaler did not reload");
  alarm_sticky_a: assert property (alarmFlag_ff[0] && !alarmClr[0] |=> alarmFlag_ff[0])
    else $error("alarm flag dropped without clear");
  wk_reload_a: assert property (evtSet[1] |=> wkFlag_ff && wkCnt_ff == $past(wkReload))
    else $error("wakeup counter did not reload and flag");
  cal_toggle_a: assert property (calEn && kTick && calCnt_ff == CAL_HALF_END ##1 calEn
                                 |-> calOut_ff != $past(calOut_ff))
    else $error("calibration output missed a toggle");
  bkp_keep_a: assert property (bkpWr_s |=> bkpRdata_ff == $past(bkpWdata, 2))
    else $error("backup word read back wrong");
  evt_route_a: assert property (evtSet[2] && evtRoute[2] |=> evtLine_ff[2] && wakeStop_ff)
    else $error("tamper event not routed");
  standby_pin_a: assert property ($rose(wakeupPin) |=> wakeStandby_ff)
    else $error("wakeup pin rise did not request standby exit");
endmodule : rtcb_calendar

// ---- rtcb_pkg.sv ----
// Purpose: Shared constants, types and BCD helpers for the calendar clock block
// Assumes: Kernel clock sources arrive as synchronous levels sampled on clk
// Notes:   All BCD fields are two packed digits, low digit in bits 3:0
package rtcb_pkg;
  localparam int          PRESC_W      = 20;
  localparam logic [19:0] PRESC_RST    = 20'h07fff;
  localparam logic [6:0]  FAST_DIV_END = 7'h7f;
  localparam logic [4:0]  CAL_HALF_END = 5'h1f;
  localparam logic [5:0]  REF50_END    = 6'h31;
  localparam logic [5:0]  REF60_END    = 6'h3b;
  localparam logic [1:0]  REF_MISS_MAX = 2'h2;
  localparam int          BKP_N        = 20;
  localparam int          BKP_AW       = 5;
  localparam logic [7:0]  SEC_END      = 8'h59;
  localparam logic [7:0]  MIN_END      = 8'h59;
  localparam logic [7:0]  HOUR24_END   = 8'h23;
  localparam logic [7:0]  HOUR12_LAST  = 8'h11;
  localparam logic [7:0]  HOUR12_TOP   = 8'h12;
  localparam logic [7:0]  MONTH_END    = 8'h12;
  localparam logic [7:0]  YEAR_END     = 8'h99;
  localparam logic [2:0]  WDAY_END     = 3'h7;
  localparam logic [7:0]  TIME_RST     = 8'h00;
  localparam logic [7:0]  DATE_RST     = 8'h01;
  localparam logic [2:0]  WDAY_RST     = 3'h1;
  localparam logic [7:0]  HOUR12_RST   = 8'h01;

  typedef enum logic [1:0] {
    RTCB_CK_XTAL = 2'b00,
    RTCB_CK_LSRC = 2'b01,
    RTCB_CK_FAST = 2'b10
  } rtcb_cksrc_t;

  typedef enum logic [2:0] {
    RTCB_WK_DIV16 = 3'b000,
    RTCB_WK_DIV8  = 3'b001,
    RTCB_WK_DIV4  = 3'b010,
    RTCB_WK_DIV2  = 3'b011,
    RTCB_WK_SEC   = 3'b100
  } rtcb_wkres_t;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : is_leap

  function automatic logic [7:0] days_in_month(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02:                      days_in_month = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
      default:                    days_in_month = 8'h31;
    endcase
  endfunction : days_in_month
endpackage : rtcb_pkg

// ---- rtcb_backup_mem.sv ----
// Purpose: Retained backup word store
// Assumes: Writes beyond the last word are dropped
// Notes:   No reset reaches the array, so no reset kind can clear it
`timescale 1ns/1ps
module rtcb_backup_mem
  import rtcb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [BKP_AW-1:0] addr,
  input  wire logic [31:0]       wdata,
  output logic      [31:0]       rdata_ff
);
  logic [31:0] mem [BKP_N];

  always_ff @(posedge clk) begin
    if (we && (addr < BKP_AW'(BKP_N))) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_ff <= (addr < BKP_AW'(BKP_N)) ? mem[addr] : 32'h0000_0000;
  end
endmodule : rtcb_backup_mem

// ---- rtcb_calendar_tb.sv ----
// Purpose: Self-checking bench for the BCD calendar clock block
// Assumes: Crystal source selected; prescaler shortened to four kernel ticks a second
// Notes:   Kernel ticks are made by hand, so one second is exactly four ticks
`timescale 1ns/1ps
module rtcb_calendar_tb;
  import rtcb_pkg::*;
  logic                 clk = 1'b0, rstn = 1'b0, ckXtal = 1'b0, ckLowRc = 1'b0, ckFastExt = 1'b0;
  rtcb_cksrc_t          ckSel = RTCB_CK_XTAL;
  rtcb_wkres_t          wkSel = RTCB_WK_DIV2;
  logic                 prescWr = 1'b0, refEn = 1'b0, ref60Hz = 1'b0, refIn = 1'b0, calEn = 1'b0;
  logic [19:0]          prescVal = 20'h07fff;
  logic                 fmt12 = 1'b0, setStb = 1'b0, setPm = 1'b0;
  logic [7:0]           setSec = '0, setMin = '0, setHour = '0, setDate = '0, setMonth = '0;
  logic [7:0]           setYear = '0;
  logic [2:0]           setWday = 3'h1;
  logic [1:0]           alarmEn = '0, alarmPm = '0, alarmWdSel = '0, alarmClr = '0;
  logic [1:0][19:0]     alarmSub = '0;
  logic [1:0][7:0]      alarmSec = '0, alarmMin = '0, alarmHour = '0, alarmDay = '0;
  logic [1:0][4:0]      alarmMask = '0;
  logic                 wkEn = 1'b0, wkClr = 1'b0, tamperIn = 1'b0, tamperClr = 1'b0;
  logic                 stampIn = 1'b0, stampClr = 1'b0, extResetPinN = 1'b1, watchdogRst = 1'b0;
  logic                 wakeupPin = 1'b0, bkpWe = 1'b0;
  logic [15:0]          wkReload = 16'h0001;
  logic [3:0]           evtRoute = '0, evtSeen = '0;
  logic [BKP_AW-1:0]    bkpAddr = '0;
  logic [31:0]          bkpWdata = '0, bkpRdata_ff;
  logic [7:0]           sec_ff, min_ff, hour_ff, date_ff, month_ff, year_ff;
  logic [2:0]           wday_ff;
  logic [19:0]          subSec_ff;
  logic [1:0]           alarmFlag_ff;
  logic [3:0]           evtLine_ff;
  logic                 pm_ff, refDetected_ff, calOut_ff, wkFlag_ff, tamperFlag_ff, stampFlag_ff;
  logic                 wakeStop_ff, wakeStandby_ff, stopSeen = 1'b0, sbySeen = 1'b0, calSeen = 1'b0;
  int                   mismatches = 0, samplesChecked = 0;
  localparam logic [7:0] DIN [6] = '{8'h31, 8'h28, 8'h28, 8'h29, 8'h30, 8'h30};
  localparam logic [7:0] MIN_ [6] = '{8'h12, 8'h02, 8'h02, 8'h02, 8'h04, 8'h01};
  localparam logic [7:0] YIN [6] = '{8'h99, 8'h01, 8'h04, 8'h04, 8'h05, 8'h05};
  localparam logic [7:0] DEX [6] = '{8'h01, 8'h01, 8'h29, 8'h01, 8'h01, 8'h31};
  localparam logic [7:0] MEX [6] = '{8'h01, 8'h03, 8'h02, 8'h03, 8'h05, 8'h01};
  localparam logic [7:0] YEX [6] = '{8'h00, 8'h01, 8'h04, 8'h04, 8'h05, 8'h05};

  rtcb_calendar uut (.clk, .rstn, .ckSel, .ckXtal, .ckLowRc, .ckFastExt, .prescWr, .prescVal,
    .refEn, .ref60Hz, .refIn, .calEn, .fmt12, .setStb, .setSec, .setMin, .setHour, .setPm,
    .setWday, .setDate, .setMonth, .setYear, .alarmEn, .alarmSub, .alarmSec, .alarmMin,
    .alarmHour, .alarmPm, .alarmDay, .alarmWdSel, .alarmMask, .alarmClr, .wkEn, .wkSel,
    .wkReload, .wkClr, .tamperIn, .tamperClr, .stampIn, .stampClr, .evtRoute, .extResetPinN,
    .watchdogRst, .wakeupPin, .bkpWe, .bkpAddr, .bkpWdata, .bkpRdata_ff, .sec_ff, .min_ff,
    .hour_ff, .pm_ff, .wday_ff, .date_ff, .month_ff, .year_ff, .subSec_ff, .refDetected_ff,
    .calOut_ff, .alarmFlag_ff, .wkFlag_ff, .tamperFlag_ff, .stampFlag_ff, .evtLine_ff,
    .wakeStop_ff, .wakeStandby_ff);

  always #50 clk = ~clk;

  // Pulses last one cycle, so they are caught mid-cycle where they are settled
  always @(negedge clk) begin
    evtSeen = evtSeen | evtLine_ff;
    if (wakeStop_ff === 1'b1) stopSeen = 1'b1;
    if (wakeStandby_ff === 1'b1) sbySeen = 1'b1;
    if (calOut_ff === 1'b1) calSeen = 1'b1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic ktick();
    ckXtal = 1'b1;
    cyc(1);
    ckXtal = 1'b0;
    cyc(1);
  endtask : ktick

  task automatic set_time(input logic [7:0] h, input logic p, input logic [7:0] d,
                          input logic [7:0] mo, input logic [7:0] y);
    {setHour, setPm, setMin, setSec, setWday} = {h, p, 8'h59, 8'h59, 3'h7};
    {setDate, setMonth, setYear, setStb} = {d, mo, y, 1'b1};
    cyc(1);
    setStb = 1'b0;
  endtask : set_time

  task automatic give_verdict();
    if (mismatches == 0 && samplesChecked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic t_reset_backup();
    check("subSec", subSec_ff, 20'h07fff);
    check("date", {wday_ff, date_ff, month_ff, year_ff}, {3'h1, 24'h010100});
    {bkpWe, bkpAddr, bkpWdata} = {1'b1, 5'd20, 32'hffffffff};
    cyc(1);
    {bkpAddr, bkpWdata} = {5'd19, 32'h5a5a0013};
    cyc(1);
    bkpWe = 1'b0;
    cyc(2);
    check("bkp19w", bkpRdata_ff, 32'h5a5a0013);
    bkpAddr = 5'd20;
    cyc(2);
    check("bkp20", bkpRdata_ff, 32'h0);
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    bkpAddr = 5'd19;
    cyc(3);
    check("bkp19", bkpRdata_ff, 32'h5a5a0013);
  endtask : t_reset_backup

  task automatic t_prescaler();
    {prescVal, prescWr} = {20'h00003, 1'b1};
    cyc(1);
    prescWr = 1'b0;
    for (int i = 0; i < 33000 && subSec_ff !== 20'h0; i++) ktick();
    ktick();
    check("subSecReload", subSec_ff, 20'h00003);
    ktick();
    check("subSecDown", subSec_ff, 20'h00002);
  endtask : t_prescaler

  task automatic t_rollover();
    for (int i = 0; i < 6; i++) begin
      set_time(8'h23, 1'b0, DIN[i], MIN_[i], YIN[i]);
      repeat (4) ktick();
      check("time", {hour_ff, min_ff, sec_ff, wday_ff}, {24'h0, 3'h1});
      check("date", {date_ff, month_ff, year_ff}, {DEX[i], MEX[i], YEX[i]});
    end
    fmt12 = 1'b1;
    set_time(8'h11, 1'b0, 8'h10, 8'h06, 8'h05);
    repeat (4) ktick();
    check("noon", {hour_ff, pm_ff, date_ff}, {8'h12, 1'b1, 8'h10});
    set_time(8'h11, 1'b1, 8'h10, 8'h06, 8'h05);
    repeat (4) ktick();
    check("midnight", {hour_ff, pm_ff, date_ff}, {8'h12, 1'b0, 8'h11});
    fmt12 = 1'b0;
  endtask : t_rollover

  task automatic t_alarm();
    {alarmMask, alarmSec, alarmMin} = {5'h1e, 5'h1e, 8'h30, 8'h00, 8'h00, 8'h45};
    {alarmDay[0], alarmEn, evtRoute} = {8'h15, 2'b11, 4'h1};
    set_time(8'h00, 1'b0, 8'h01, 8'h01, 8'h00);
    {evtSeen, stopSeen} = '0;
    repeat (4) ktick();
    check("alarmFlag", alarmFlag_ff, 2'b01);
    check("alarmWake", {evtSeen, stopSeen}, {4'h1, 1'b1});
    alarmClr = 2'b01;
    cyc(1);
    alarmClr = 2'b00;
    cyc(1);
    check("alarmClr", alarmFlag_ff, 2'b00);
    alarmEn = 2'b00;
  endtask : t_alarm

  task automatic t_events();
    {evtRoute, evtSeen, sbySeen, tamperIn} = {4'hc, 4'h0, 1'b0, 1'b1};
    cyc(3);
    check("tamper", {tamperFlag_ff, stampFlag_ff, evtSeen, sbySeen}, 7'h49);
    stampIn = 1'b1;
    cyc(3);
    check("stamp", {stampFlag_ff, evtSeen}, 5'h1c);
    {tamperIn, stampIn, tamperClr, stampClr} = 4'h3;
    cyc(1);
    {tamperClr, stampClr, sbySeen, wakeupPin} = 4'h1;
    cyc(3);
    check("evtClr", {tamperFlag_ff, stampFlag_ff, sbySeen}, 3'h1);
    {wakeupPin, watchdogRst} = 2'b01;
    cyc(2);
    check("wdog", wakeStandby_ff, 1'b1);
    {watchdogRst, extResetPinN} = 2'b00;
    cyc(2);
    check("pin", wakeStandby_ff, 1'b1);
    extResetPinN = 1'b1;
    cyc(2);
    check("idle", wakeStandby_ff, 1'b0);
  endtask : t_events

  task automatic t_wakeup_cal();
    {evtRoute, evtSeen, calSeen, wkEn} = {4'h2, 4'h0, 1'b0, 1'b1};
    repeat (2) ktick();
    check("wkEarly", {wkFlag_ff, calSeen}, 2'b00);
    repeat (4) ktick();
    check("wkFlag", {wkFlag_ff, evtSeen}, {1'b1, 4'h2});
    wkClr = 1'b1;
    cyc(1);
    {wkClr, wkEn, calEn} = 3'b001;
    cyc(1);
    check("wkClr", wkFlag_ff, 1'b0);
    repeat (64) ktick();
    check("calOut", calSeen, 1'b1);
  endtask : t_wakeup_cal

  // No kernel ticks here, so only the 50th reference edge can advance the seconds
  task automatic t_reference();
    refEn = 1'b1;
    set_time(8'h10, 1'b0, 8'h01, 8'h01, 8'h00);
    for (int i = 0; i < 50; i++) begin
      refIn = 1'b1;
      cyc(1);
      refIn = 1'b0;
      cyc(1);
    end
    check("refSec", {hour_ff, min_ff, sec_ff}, 24'h110000);
    check("refDet", refDetected_ff, 1'b1);
    refEn = 1'b0;
  endtask : t_reference

  initial begin
    cyc(10);
    rstn = 1'b1;
    cyc(3);
    t_reset_backup();
    t_prescaler();
    t_rollover();
    t_alarm();
    t_events();
    t_wakeup_cal();
    t_reference();
    give_verdict();
  end

  // Worst case is the prescaler drain from its reset count, about 66000 cycles
  initial begin
    #9ms;
    mismatches++;
    give_verdict();
  end
endmodule : rtcb_calendar_tb
